/* backup_cfg.svh */
/*
  Constants of the backup-mode output control: positions of the synchronised
  input bits and the reset values of the registered outputs.
  Assumes inclusion by bare name from the design files that need them.
*/
`ifndef BACKUP_CFG_SVH
`define BACKUP_CFG_SVH

`define BMC_NUM_INPUTS 10
`define BMC_IN_SUPPLY_LOW 0
`define BMC_IN_BACKUP 1
`define BMC_IN_PF_BELOW 2
`define BMC_IN_RESET_HOLD 3
`define BMC_IN_KICK 4
`define BMC_IN_KICK_FLOAT 5
`define BMC_IN_WD_TIMEOUT 6
`define BMC_IN_TB_INPUT 7
`define BMC_IN_TB_SELECT 8
`define BMC_IN_CE_N 9

`define BMC_RST_RESET_N 1'h0
`define BMC_RST_RESET_HI 1'h1
`define BMC_RST_LOW_LINE_N 1'h0
`define BMC_RST_PF_WARN_N 1'h0
`define BMC_RST_WD_STATUS 1'h1
`define BMC_RST_BACKUP_ACTIVE 1'h0
`define BMC_RST_CE_OUT_N 1'h1
`define BMC_RST_WD_ENABLE 1'h0
`define BMC_RST_TB_INTERNAL 1'h1
`define BMC_RST_PERIOD_LONG 1'h1
`define BMC_RST_KICK_PREV 1'h0

`endif

/* backup_pkg.sv */
/*
  Types shared by the backup-mode output control.
  Assumes nothing of its surroundings.
*/
package backup_pkg;

  typedef enum logic [0:0] {
    MODE_NORMAL = 1'b0,
    MODE_BACKUP = 1'b1
  } supply_mode_t;

endpackage

/* pin_sync.sv */
/*
  Two-flop synchroniser for a vector of pin-level inputs.
  Assumes each bit is a slow level from outside the clk_sys domain.
*/
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] stage2_r;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          stage1_r[i] <= 1'h0;
          stage2_r[i] <= 1'h0;
        end else if (clk_en) begin
          stage1_r[i] <= async_in[i];
          stage2_r[i] <= stage1_r[i];
        end
      end
    end
  endgenerate

  assign sync_out = stage2_r;

endmodule

`default_nettype wire

/* backup_mode_output_control.sv */
/*
  Output forcing logic of a supervisor: drives reset, supply-low, power-fail
  warning, watchdog status, backup indicator and gated chip enable, and forces
  them to fixed levels during battery backup.
  Assumes comparator results, the reset pulse timer, the watchdog timeout and
  the floating-input detector arrive as asynchronous logic levels.
*/
// Overview of operation
// - Outside backup, power-fail warning low while sense input is below reference, else high.
// - In backup, reset, supply-low and power-fail warning outputs are low.
// - In backup, watchdog status and backup indicator outputs are high.
// - In backup, the active-high reset output is high.
// - In backup, kick, timebase input and timebase select change nothing.
// - In backup, the chip-enable input has no effect on the gated output.
// - In backup, the power-fail comparator result is disregarded.
// - Gated chip-enable output is held high throughout backup.
// - A floating kick input disables the watchdog; the processor may float it.
// - With supply valid, the gated chip enable copies the chip-enable input.
// - With supply valid, watchdog status goes low on timeout; a kick transition or supply-low sets it high again.
// - Outside backup, active-high reset is the complement of active-low reset.
`timescale 1ns/1ps
`default_nettype none
`include "backup_cfg.svh"

module backup_mode_output_control (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic supply_low_in,
  input wire logic backup_mode_in,
  input wire logic power_fail_sense_input,
  input wire logic reset_hold_in,
  input wire logic watchdog_kick_input,
  input wire logic kick_floating_in,
  input wire logic watchdog_timeout_in,
  input wire logic timebase_input,
  input wire logic timebase_select,
  input wire logic chip_enable_n_in,
  output logic reset_n_out,
  output logic reset_out,
  output logic low_line_n_out,
  output logic power_fail_warning_out,
  output logic watchdog_status_out,
  output logic backup_active_out,
  output logic chip_enable_n_out,
  output logic watchdog_enable_out,
  output logic timebase_internal_out,
  output logic period_long_out
);

  logic [`BMC_NUM_INPUTS-1:0] pins_async;
  logic [`BMC_NUM_INPUTS-1:0] pins;
  logic s_supply_low;
  logic s_backup;
  logic s_pf_below;
  logic s_reset_hold;
  logic s_kick;
  logic s_float;
  logic s_timeout;
  logic s_ce_n;
  logic kick_edge;

  backup_pkg::supply_mode_t mode_r;
  backup_pkg::supply_mode_t mode_nxt;
  logic reset_n_r, reset_n_nxt;
  logic reset_hi_r, reset_hi_nxt;
  logic low_line_n_r, low_line_n_nxt;
  logic pf_warn_n_r, pf_warn_n_nxt;
  logic wd_status_r, wd_status_nxt;
  logic backup_active_r, backup_active_nxt;
  logic ce_out_n_r, ce_out_n_nxt;
  logic wd_enable_r, wd_enable_nxt;
  logic tb_internal_r, tb_internal_nxt;
  logic period_long_r, period_long_nxt;
  logic kick_prev_r, kick_prev_nxt;

  assign pins_async[`BMC_IN_SUPPLY_LOW] = supply_low_in;
  assign pins_async[`BMC_IN_BACKUP] = backup_mode_in;
  assign pins_async[`BMC_IN_PF_BELOW] = power_fail_sense_input;
  assign pins_async[`BMC_IN_RESET_HOLD] = reset_hold_in;
  assign pins_async[`BMC_IN_KICK] = watchdog_kick_input;
  assign pins_async[`BMC_IN_KICK_FLOAT] = kick_floating_in;
  assign pins_async[`BMC_IN_WD_TIMEOUT] = watchdog_timeout_in;
  assign pins_async[`BMC_IN_TB_INPUT] = timebase_input;
  assign pins_async[`BMC_IN_TB_SELECT] = timebase_select;
  assign pins_async[`BMC_IN_CE_N] = chip_enable_n_in;

  pin_sync #(
    .WIDTH(`BMC_NUM_INPUTS)
  ) u_pin_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .clk_en(clk_en),
    .async_in(pins_async),
    .sync_out(pins)
  );

  assign s_supply_low = pins[`BMC_IN_SUPPLY_LOW];
  assign s_backup = pins[`BMC_IN_BACKUP];
  assign s_pf_below = pins[`BMC_IN_PF_BELOW];
  assign s_reset_hold = pins[`BMC_IN_RESET_HOLD];
  assign s_kick = pins[`BMC_IN_KICK];
  assign s_float = pins[`BMC_IN_KICK_FLOAT];
  assign s_timeout = pins[`BMC_IN_WD_TIMEOUT];
  assign s_ce_n = pins[`BMC_IN_CE_N];

  // A kick level left over from before backup is not taken as a transition.
  assign kick_edge = (s_kick != kick_prev_r) && (mode_r == backup_pkg::MODE_NORMAL);

  // Mode tracking follows the power-switch comparator.
  always_comb begin
    mode_nxt = mode_r;
    if (clk_en) begin
      case (mode_r)
        backup_pkg::MODE_NORMAL: begin
          if (s_backup) begin
            mode_nxt = backup_pkg::MODE_BACKUP;
          end
        end
        backup_pkg::MODE_BACKUP: begin
          if (!s_backup) begin
            mode_nxt = backup_pkg::MODE_NORMAL;
          end
        end
        default: begin
          mode_nxt = backup_pkg::MODE_BACKUP;
        end
      endcase
    end
  end

  always_comb begin
    reset_n_nxt = reset_n_r;
    reset_hi_nxt = reset_hi_r;
    low_line_n_nxt = low_line_n_r;
    pf_warn_n_nxt = pf_warn_n_r;
    wd_status_nxt = wd_status_r;
    backup_active_nxt = backup_active_r;
    ce_out_n_nxt = ce_out_n_r;
    wd_enable_nxt = wd_enable_r;
    tb_internal_nxt = tb_internal_r;
    period_long_nxt = period_long_r;
    kick_prev_nxt = kick_prev_r;
    if (clk_en) begin
      if (s_backup) begin
        // Every control input is disregarded here; timebase and kick state hold.
        reset_n_nxt = 1'h0;
        low_line_n_nxt = 1'h0;
        pf_warn_n_nxt = 1'h0;
        reset_hi_nxt = 1'h1;
        wd_status_nxt = 1'h1;
        backup_active_nxt = 1'h1;
        ce_out_n_nxt = 1'h1;
        wd_enable_nxt = 1'h0;
      end else begin
        reset_n_nxt = !(s_supply_low || s_reset_hold);
        reset_hi_nxt = s_supply_low || s_reset_hold;
        low_line_n_nxt = !s_supply_low;
        pf_warn_n_nxt = !s_pf_below;
        backup_active_nxt = 1'h0;
        // Below the reset threshold the chip enable is blocked as well.
        ce_out_n_nxt = s_supply_low ? 1'h1 : s_ce_n;
        wd_enable_nxt = !s_float;
        tb_internal_nxt = pins[`BMC_IN_TB_SELECT];
        period_long_nxt = pins[`BMC_IN_TB_INPUT];
        kick_prev_nxt = s_kick;
        if (s_supply_low) begin
          wd_status_nxt = 1'h1;
        end else if (kick_edge) begin
          wd_status_nxt = 1'h1;
        end else if (s_timeout && !s_float) begin
          wd_status_nxt = 1'h0;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mode_r <= backup_pkg::MODE_NORMAL;
      reset_n_r <= `BMC_RST_RESET_N;
      reset_hi_r <= `BMC_RST_RESET_HI;
      low_line_n_r <= `BMC_RST_LOW_LINE_N;
      pf_warn_n_r <= `BMC_RST_PF_WARN_N;
      wd_status_r <= `BMC_RST_WD_STATUS;
      backup_active_r <= `BMC_RST_BACKUP_ACTIVE;
      ce_out_n_r <= `BMC_RST_CE_OUT_N;
      wd_enable_r <= `BMC_RST_WD_ENABLE;
      tb_internal_r <= `BMC_RST_TB_INTERNAL;
      period_long_r <= `BMC_RST_PERIOD_LONG;
      kick_prev_r <= `BMC_RST_KICK_PREV;
    end else begin
      mode_r <= mode_nxt;
      reset_n_r <= reset_n_nxt;
      reset_hi_r <= reset_hi_nxt;
      low_line_n_r <= low_line_n_nxt;
      pf_warn_n_r <= pf_warn_n_nxt;
      wd_status_r <= wd_status_nxt;
      backup_active_r <= backup_active_nxt;
      ce_out_n_r <= ce_out_n_nxt;
      wd_enable_r <= wd_enable_nxt;
      tb_internal_r <= tb_internal_nxt;
      period_long_r <= period_long_nxt;
      kick_prev_r <= kick_prev_nxt;
    end
  end

  assign reset_n_out = reset_n_r;
  assign reset_out = reset_hi_r;
  assign low_line_n_out = low_line_n_r;
  assign power_fail_warning_out = pf_warn_n_r;
  assign watchdog_status_out = wd_status_r;
  assign backup_active_out = backup_active_r;
  assign chip_enable_n_out = ce_out_n_r;
  assign watchdog_enable_out = wd_enable_r;
  assign timebase_internal_out = tb_internal_r;
  assign period_long_out = period_long_r;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // At the edge that releases reset the outputs still hold reset values, so the
  // sampled reset keeps that attempt from comparing them against the inputs.
  a_pf_follows_sense: assert property (
    !rst && clk_en && !s_backup |=> power_fail_warning_out == !$past(s_pf_below)
  ) else $error("power-fail warning does not follow the comparator");

  a_bk_low_outputs: assert property (
    clk_en && s_backup |=> !reset_n_out && !low_line_n_out && !power_fail_warning_out
  ) else $error("backup did not drive reset, low-line and warning low");

  a_bk_high_outputs: assert property (
    clk_en && s_backup |=> watchdog_status_out && backup_active_out
  ) else $error("backup did not drive watchdog status and indicator high");

  a_bk_reset_high: assert property (
    clk_en && s_backup |=> reset_out
  ) else $error("backup did not drive the active-high reset high");

  a_bk_timebase_hold: assert property (
    clk_en && s_backup |=> $stable(timebase_internal_out) && $stable(period_long_out)
  ) else $error("timebase selection changed during backup");

  a_bk_ce_forced: assert property (
    (clk_en && s_backup) [*2] |=> chip_enable_n_out && $stable(chip_enable_n_out)
  ) else $error("gated chip enable not held high in backup");

  a_float_disables_wd: assert property (
    clk_en && !s_backup && s_float && !s_supply_low && !kick_edge |=>
      $stable(watchdog_status_out) && !watchdog_enable_out
  ) else $error("floating kick input did not disable the watchdog");

  a_ce_passthrough: assert property (
    !rst && clk_en && !s_backup && !s_supply_low |=> chip_enable_n_out == $past(s_ce_n)
  ) else $error("gated chip enable is not a copy of the input");

  a_wd_timeout_low: assert property (
    clk_en && !s_backup && !s_supply_low && !s_float && s_timeout && !kick_edge |=>
      !watchdog_status_out
  ) else $error("watchdog status did not fall on timeout");

  a_reset_complement: assert property (
    clk_en && !s_backup |=> reset_out != reset_n_out
  ) else $error("active-high reset is not the complement outside backup");

  c_enter_backup: cover property (clk_en && !s_backup ##1 clk_en && s_backup [*2]);
  c_wd_timeout: cover property (clk_en && s_timeout && !s_float ##1 !watchdog_status_out);
  c_pf_warning: cover property (clk_en && !s_backup && s_pf_below ##1 !power_fail_warning_out);
  c_kick_restore: cover property (!watchdog_status_out ##1 clk_en && kick_edge);

endmodule

`default_nettype wire

/* cpu_ram_model.sv */
/*
  Behavioural model of the processor and battery-backed RAM on the far side.
  Assumes the bench asks for kicks, deselects and a released kick line.
*/
`timescale 1ns/1ps
`default_nettype none

module cpu_ram_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic chip_enable_n_out,
  input wire logic ce_off,
  input wire logic float_req,
  input wire logic kick_req,
  output logic watchdog_kick_input,
  output logic kick_floating_in,
  output logic chip_enable_n_in,
  output int ram_writes
);
  // A released kick line rests at the pull-up level, so it shows no transitions.
  always @(posedge clk_sys) begin
    if (rst) begin
      watchdog_kick_input <= 1'b0;
      kick_floating_in <= 1'b0;
      chip_enable_n_in <= 1'b1;
      ram_writes <= 0;
    end else begin
      if (float_req) begin
        watchdog_kick_input <= 1'b1;
      end else begin
        watchdog_kick_input <= kick_req;
      end
      kick_floating_in <= float_req;
      chip_enable_n_in <= ce_off;
      if (!chip_enable_n_out) begin
        ram_writes <= ram_writes + 1;
      end
    end
  end
endmodule

`default_nettype wire

/* backup_mode_output_control_bench.sv */
/*
  Self-checking bench for the backup-mode output control.
  Assumes a 40 MHz clock and outputs settled six enabled edges after inputs.
*/
`timescale 1ns/1ps
`default_nettype none

module backup_mode_output_control_bench;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic [9:0] s = 10'h000;
  logic kick, kfl, cen;
  wire [9:0] o;
  int ram_writes;
  int error_cnt = 0;
  int compares = 0;
  int w0;

  always #12.5 clk_sys = !clk_sys;

  backup_mode_output_control dut (
    .clk_sys(clk_sys), .rst(rst), .clk_en(clk_en),
    .supply_low_in(s[9]), .backup_mode_in(s[8]), .power_fail_sense_input(s[7]),
    .reset_hold_in(s[6]), .watchdog_timeout_in(s[5]), .timebase_input(s[4]),
    .timebase_select(s[3]), .watchdog_kick_input(kick), .kick_floating_in(kfl),
    .chip_enable_n_in(cen),
    .reset_n_out(o[9]), .reset_out(o[8]), .low_line_n_out(o[7]),
    .power_fail_warning_out(o[6]), .watchdog_status_out(o[5]),
    .backup_active_out(o[4]), .chip_enable_n_out(o[3]), .watchdog_enable_out(o[2]),
    .timebase_internal_out(o[1]), .period_long_out(o[0])
  );

  cpu_ram_model far_side (
    .clk_sys(clk_sys), .rst(rst), .chip_enable_n_out(o[3]), .ce_off(s[2]),
    .float_req(s[1]), .kick_req(s[0]), .watchdog_kick_input(kick),
    .kick_floating_in(kfl), .chip_enable_n_in(cen), .ram_writes(ram_writes)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Drives one stimulus set, lets it cross the synchronisers, then compares.
  task automatic run(input logic [9:0] stim, input logic [9:0] exp);
    @(posedge clk_sys);
    s <= stim;
    repeat (6) @(posedge clk_sys);
    #1;
    chk(32'(o), 32'(exp));
  endtask

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (2000) @(posedge clk_sys);
    error_cnt++;
    test_done();
  end

  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    run(10'h000, 10'h2E4);
    run(10'h080, 10'h2A4);
    @(posedge clk_sys);
    clk_en <= 1'b0;
    run(10'h000, 10'h2A4);
    @(posedge clk_sys);
    clk_en <= 1'b1;
    run(10'h000, 10'h2E4);
    $display("Test normal outputs done");
    run(10'h040, 10'h1E4);
    run(10'h020, 10'h2C4);
    run(10'h000, 10'h2C4);
    run(10'h001, 10'h2E4);
    run(10'h004, 10'h2EC);
    run(10'h000, 10'h2E4);
    $display("Test watchdog and chip enable done");
    run(10'h002, 10'h2E0);
    run(10'h022, 10'h2E0);
    run(10'h200, 10'h16C);
    $display("Test float and supply low done");
    w0 = ram_writes;
    run(10'h300, 10'h138);
    w0 = ram_writes;
    run(10'h3FF, 10'h138);
    run(10'h3A1, 10'h138);
    run(10'h15A, 10'h138);
    chk(ram_writes, w0);
    $display("Test backup forcing done");
    run(10'h018, 10'h2E7);
    run(10'h098, 10'h2A7);
    $display("Test leave backup done");
    test_done();
  end
endmodule

`default_nettype wire
